// ### fpc_control.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_control (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               user_mode,
	input  wire logic               control_read_instr,
	input  wire logic               control_write_instr,
	input  wire logic [31:0]        write_data,
	input  wire fpc_pkg::fpc_arith_t arith_in,
	input  wire logic               ls_bounce,
	input  wire logic               fp_instr_valid,
	output logic [31:0]             read_data,
	output logic                    read_valid,
	output logic                    undef_trap,
	output logic                    fp_instr_refused,
	output logic                    unit_disable
);
	// Field map of the control word, high bits first
	//   31     rounded_up_flag
	//   30:29  reserved, read as zero
	//   28     inexact_flag
	//   27     mantissa_overflow
	//   26     exponent_overflow
	//   25:24  reserved, read as zero
	//   23:20  arith_instr_code, high part
	//   19     arith_width_sel, high part
	//   18:16  first_source_field
	//   15     arith_instr_code, middle part
	//   14:12  target_reg_field
	//   11     store_bounce_flag
	//   10     arith_bounce_flag
	//   9      round_excess_flag
	//   8      unit_disable
	//   7      arith_width_sel, low part
	//   6:5    arith_round_sel
	//   4      arith_instr_code, low part
	//   3:0    second_source_field, bit 3 marks a constant
	// Reserved bits belong to nobody and stay at their reset value

	// Control word and its next value
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;

	// Answer registers and their next values
	logic [31:0] read_data_reg;
	logic [31:0] read_data_next;
	logic        read_valid_reg;
	logic        read_valid_next;
	logic        undef_trap_reg;
	logic        undef_trap_next;

	// Access decode
	logic        host_access;
	logic        user_access;
	logic        rd_ok;
	logic        wr_ok;

	// Hardware update sources
	logic [31:0] arith_word;
	logic        arith_update;
	logic        arith_bounce;
	logic [31:0] arith_bounce_vec;
	logic [31:0] store_bounce_vec;
	logic [31:0] bounce_set;

	// Current disable state
	logic        disable_now;

	// Any control instruction offered this cycle
	assign host_access = control_read_instr || control_write_instr;

	// User mode turns the access into a trap
	assign user_access = host_access && user_mode;

	// Privileged read; a read wins a collision
	assign rd_ok = control_read_instr && !user_mode;

	// Privileged write, dropped when a read collides
	assign wr_ok = control_write_instr && !user_mode && !control_read_instr;

	// Arithmetic unit carrier split
	assign arith_word = arith_in.word;
	assign arith_update = arith_in.update;
	assign arith_bounce = arith_in.bounce;

	// One-hot bounce requests
	assign arith_bounce_vec = {31'h0000_0000, arith_bounce} << fpc_pkg::ARITH_BOUNCE_BIT;
	assign store_bounce_vec = {31'h0000_0000, ls_bounce} << fpc_pkg::STORE_BOUNCE_BIT;
	assign bounce_set = arith_bounce_vec | store_bounce_vec;

	assign disable_now = ctrl_reg[fpc_pkg::UNIT_DISABLE_BIT];

	// Next value, one bit at a time
	// Per bit: arithmetic load, then host access, then bounce set
	for (genvar i = 0; i < fpc_pkg::WORD_W; i++) begin : g_bit
		logic host_owned;
		logic arith_owned;
		logic arith_load;
		logic write_hit;
		logic clear_hit;
		logic hw_set;
		logic bit_after_arith;
		logic bit_after_host;

		// Ownership of this bit
		assign host_owned = fpc_pkg::HOST_MASK[i];
		assign arith_owned = fpc_pkg::ARITH_MASK[i];

		// Arithmetic unit loads only its own fields
		assign arith_load = arith_update && arith_owned;
		assign bit_after_arith = arith_load ? arith_word[i] : ctrl_reg[i];

		// Host write loads, host read clears, host-owned bits only
		assign write_hit = wr_ok && host_owned;
		assign clear_hit = rd_ok && host_owned;
		assign bit_after_host = write_hit
			? write_data[i]
			: clear_hit
			? 1'b0
			: bit_after_arith;

		// A hardware bounce in the same cycle wins over the host
		assign hw_set = bounce_set[i];
		assign ctrl_next[i] = bit_after_host | hw_set;
	end

	// Answer values
	assign read_valid_next = rd_ok;
	assign undef_trap_next = user_access;
	// Captured before the read clears the control bits
	assign read_data_next = rd_ok ? ctrl_reg : read_data_reg;

	// Control word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_reg <= fpc_pkg::RESET_WORD;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Read data, held until the next accepted read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			read_data_reg <= 32'h0000_0000;
		end else begin
			read_data_reg <= read_data_next;
		end
	end

	// Read answer pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			read_valid_reg <= 1'b0;
		end else begin
			read_valid_reg <= read_valid_next;
		end
	end

	// Trap pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			undef_trap_reg <= 1'b0;
		end else begin
			undef_trap_reg <= undef_trap_next;
		end
	end

	// Outputs
	assign read_data = read_data_reg;
	assign read_valid = read_valid_reg;
	assign undef_trap = undef_trap_reg;
	assign unit_disable = disable_now;

	// Disabled unit sends offered instructions to support code
	assign fp_instr_refused = fp_instr_valid && disable_now;
endmodule
`default_nettype wire

// ### fpc_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_props (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        user_mode,
	input wire logic        control_read_instr,
	input wire logic        control_write_instr,
	input wire logic [31:0] write_data,
	input wire logic        fp_instr_valid,
	input wire logic        read_valid,
	input wire logic        undef_trap,
	input wire logic        fp_instr_refused,
	input wire logic        unit_disable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_trap; (control_read_instr||control_write_instr)&&user_mode |=> undef_trap&&!read_valid; endproperty
	a_trap: assert property (p_trap) else $error("no trap");
	property p_read; control_read_instr&&!user_mode |=> read_valid&&!unit_disable; endproperty
	a_read: assert property (p_read) else $error("bad read");
	property p_wr; control_write_instr&&!control_read_instr&&!user_mode |=> unit_disable==$past(write_data[8]); endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_hold; !control_read_instr&&!control_write_instr |=> $stable(unit_disable); endproperty
	a_hold: assert property (p_hold) else $error("disable moved");
	property p_ref; fp_instr_refused==(fp_instr_valid&&unit_disable); endproperty
	a_ref: assert property (p_ref) else $error("bad refusal");
	property p_rst; disable iff (1'b0) rst |=> unit_disable&&!read_valid&&!undef_trap; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_user; (control_read_instr||control_write_instr)&&user_mode
		|=> $stable(unit_disable); endproperty
	a_user: assert property (p_user) else $error("user access changed word");
endmodule
bind fpc_control fpc_props u_props(.clk_sys, .rst, .user_mode, .control_read_instr,
	.control_write_instr, .write_data, .fp_instr_valid, .read_valid, .undef_trap,
	.fp_instr_refused, .unit_disable);
`default_nettype wire

// ### fpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_host (
	input  wire logic        clk_sys,
	output logic             user_mode,
	output logic             control_read_instr,
	output logic             control_write_instr,
	output logic [31:0]      write_data
);
	initial {user_mode, control_read_instr, control_write_instr, write_data} = '0;
	// One instruction, held one edge
	task automatic op(input logic r, w, u, input logic [31:0] d);
		@(posedge clk_sys) #1;
		{control_read_instr, control_write_instr, user_mode, write_data} = {r, w, u, d};
		@(posedge clk_sys) #1;
		{control_read_instr, control_write_instr, user_mode} = '0;
		write_data = ~d;
	endtask
endmodule
`default_nettype wire

// ### fpc_pkg.sv
// Function
// - User-mode control access traps, no register access
// - Register holds unit disable and bounce information
// - Reset clears all except disable, bounce bits
// - Only arithmetic unit or write sets arith_bounce_flag
// - Only load-store unit or write sets store_bounce_flag
// - Arithmetic fields writable only by arithmetic unit
// - Read returns word then clears three control bits
// - Write updates only three control bits
package fpc_pkg;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned ROUNDED_UP_BIT = 31;
	localparam int unsigned INEXACT_BIT = 28;
	localparam int unsigned MANT_OVF_BIT = 27;
	localparam int unsigned EXP_OVF_BIT = 26;
	localparam int unsigned STORE_BOUNCE_BIT = 11;
	localparam int unsigned ARITH_BOUNCE_BIT = 10;
	localparam int unsigned ROUND_EXCESS_BIT = 9;
	localparam int unsigned UNIT_DISABLE_BIT = 8;
	// Bits writable by the control write instruction
	localparam logic [31:0] HOST_MASK = 32'h0000_0d00;
	// Bits owned by the arithmetic unit: 31, 28:26, 23:12, 9, 7:0
	localparam logic [31:0] ARITH_MASK = 32'h9cff_f2ff;
	localparam logic [31:0] RESET_WORD = 32'h0000_0d00;

	typedef struct packed {
		logic       rounded_up_flag;
		logic [1:0] rsvd_hi;
		logic       inexact_flag;
		logic       mantissa_overflow;
		logic       exponent_overflow;
		logic [1:0] rsvd_mid;
		logic [3:0] arith_instr_code_hi;
		logic       arith_width_sel_hi;
		logic [2:0] first_source_field;
		logic       arith_instr_code_mid;
		logic [2:0] target_reg_field;
		logic       store_bounce_flag;
		logic       arith_bounce_flag;
		logic       round_excess_flag;
		logic       unit_disable;
		logic       arith_width_sel_lo;
		logic [1:0] arith_round_sel;
		logic       arith_instr_code_lo;
		logic [3:0] second_source_field;
	} fpc_word_t;

	typedef struct packed {
		logic       update;
		fpc_word_t  word;
		logic       bounce;
	} fpc_arith_t;
endpackage

// ### test_fpc_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpc_control;
	logic clk_sys = 0, rst = 1, ls_bounce = 0, fp_instr_valid = 1;
	fpc_pkg::fpc_arith_t arith_in = '0;
	logic user_mode, control_read_instr, control_write_instr, read_valid, undef_trap;
	logic fp_instr_refused, unit_disable;
	logic [31:0] write_data, read_data;
	int err_count = 0, n_checks = 0;
	always #10 clk_sys = ~clk_sys;
	fpc_host host(.clk_sys, .user_mode, .control_read_instr, .control_write_instr, .write_data);
	fpc_control DUT(.clk_sys, .rst, .user_mode, .control_read_instr, .control_write_instr,
		.write_data, .arith_in, .ls_bounce, .fp_instr_valid, .read_data, .read_valid,
		.undef_trap, .fp_instr_refused, .unit_disable);
	task chk(input logic [31:0] a, e);
		n_checks++;
		if (a !== e) begin
			err_count++;
			$display("ERROR %0t %h %h", $time, a, e);
		end
	endtask
	task rd(input logic [31:0] e);
		host.op(1, 0, 0, '0);
		chk(read_data, e);
		chk(read_valid, 1);
	endtask
	task hw(input logic [31:0] w, input logic l);
		@(posedge clk_sys) #1;
		arith_in = {1'b1, w, 1'b1};
		ls_bounce = l;
		@(posedge clk_sys) #1;
		arith_in = '0;
		ls_bounce = 0;
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rst = 0;
		chk(unit_disable, 1);
		chk(fp_instr_refused, 1);
		rd(32'h0000_0d00);
		chk(fp_instr_refused, 0);
		rd(32'h0000_0000);
		host.op(0, 1, 1, '1);
		chk(undef_trap, 1);
		host.op(1, 0, 1, '0);
		chk(undef_trap, 1);
		chk(read_valid, 0);
		host.op(0, 1, 0, '1);
		chk(unit_disable, 1);
		rd(32'h0000_0d00);
		hw(32'hffff_ffff, 1);
		rd(32'h9cff_feff);
		host.op(1, 1, 0, '1);
		chk(read_data, 32'h9cff_f2ff);
		rd(32'h9cff_f2ff);
		@(posedge clk_sys) #1 rst = 1;
		@(posedge clk_sys) #1 rst = 0;
		rd(32'h0000_0d00);
		print_verdict;
	end
endmodule
`default_nettype wire
